// file: rtl/twr_latch_reg.sv
// one latch register with a load enable
`timescale 1ns/10ps
`default_nettype none

module twr_latch_reg
#(
    parameter int               W     = 20,
    parameter logic [W-1:0]     RESET = '0
)
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // load port
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    // stored value
    output logic      [W-1:0] q
);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            q <= RESET;
        else if (load)
            q <= d;
    end

endmodule : twr_latch_reg

`default_nettype wire

// file: rtl/twr_pkg.sv
// shared constants and types for the three-wire register load port
package twr_pkg;

    // serial word layout: data field above, register select in the last bits shifted in
    localparam int WORD_W      = 24;
    localparam int SEL_W       = 4;
    localparam int DATA_W      = WORD_W - SEL_W;
    localparam int NUM_REGS    = 16;
    localparam int SEL_LSB     = 0;
    localparam int DATA_LSB    = SEL_W;

    // destination that restarts the loop after power-up
    localparam logic [SEL_W-1:0] PRIMARY_SEL = 4'h0;

    // latch register holding the power-control field
    localparam logic [SEL_W-1:0] PWR_SEL     = 4'h1;
    localparam int               PWR_W       = 4;
    localparam int               PWR_LSB     = 0;

    // latch register reset value
    localparam logic [DATA_W-1:0] REG_RESET  = 20'h0_0000;

    // running bit counter on the serial clock
    localparam int               CNT_W       = 8;
    localparam logic [CNT_W-1:0] CNT_RESET   = 8'h00;

    // synchroniser depth for pins entering the system clock domain
    localparam int SYNC_STAGES = 2;

    // system clock 20 MHz and the settle time after the strobe rises
    localparam int SYS_CLK_HZ     = 20_000_000;
    localparam int SETTLE_NS      = 50;
    localparam int SETTLE_CYCLES  = (SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

    // load sequencer states
    typedef enum logic [1:0]
    {
        TWR_IDLE    = 2'b00,
        TWR_CAPTURE = 2'b01,
        TWR_COMMIT  = 2'b10,
        TWR_WAIT_LO = 2'b11
    } twr_load_state_t;

endpackage : twr_pkg

// file: rtl/twr_serial_port.sv
// three-wire serial programming port: shift register, latch bank and power control
//
// What this block does
// - word arrives most significant bit first
// - last bits shifted select the destination register
// - data sampled on each serial clock rising edge
// - strobe rising copies word into selected register
// - chip enable powers only sections enabled by bits
`timescale 1ns/10ps
`default_nettype none

module twr_serial_port
#(
    parameter int WORD_W   = twr_pkg::WORD_W,
    parameter int SEL_W    = twr_pkg::SEL_W,
    parameter int NUM_REGS = twr_pkg::NUM_REGS,
    parameter int PWR_W    = twr_pkg::PWR_W
)
(
    // system clock and reset
    input  wire logic                                  sys_clk,
    input  wire logic                                  resetn,

    // serial link pins
    input  wire logic                                  ser_clk,
    input  wire logic                                  ser_data,
    input  wire logic                                  latch_strobe,

    // chip enable pin
    input  wire logic                                  chip_enable,

    // latch register bank, register i at bits [i*DATA_W +: DATA_W]
    output logic [NUM_REGS*(WORD_W-SEL_W)-1:0]         reg_bank,

    // load reporting
    output logic                                       load_pulse,
    output logic [SEL_W-1:0]                           load_sel,
    output logic [7:0]                                 load_bits,
    output logic                                       short_word,

    // power control
    output logic [PWR_W-1:0]                           pwr_enable,
    output logic                                       powered,
    output logic                                       relock_pending
);

    localparam int DATA_W = WORD_W - SEL_W;
    localparam int CNT_W  = twr_pkg::CNT_W;

    // link domain, on the serial clock
    // the serial clock may stop between words
    // nothing here waits on the system clock

    logic [WORD_W-1:0] shift_word;
    logic [CNT_W-1:0]  bit_count;

    // no reset of its own is documented; resetn clears it so simulation starts defined
    always_ff @(posedge ser_clk or negedge resetn)
    begin
        if (!resetn)
            shift_word <= '0;
        else
            shift_word <= {shift_word[WORD_W-2:0], ser_data};
    end

    // free-running count of bits; the word length is the difference between two loads
    always_ff @(posedge ser_clk or negedge resetn)
    begin
        if (!resetn)
            bit_count <= twr_pkg::CNT_RESET;
        else
            bit_count <= bit_count + 1'b1;
    end

    // pins into the system clock domain
    // strobe and enable are asynchronous to the system clock
    // edge detection reads only the synchronised copies

    logic strobe_sync;
    logic enable_sync;

    twr_sync u_strobe_sync
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (latch_strobe),
        .sync_out (strobe_sync)
    );

    twr_sync u_enable_sync
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (chip_enable),
        .sync_out (enable_sync)
    );

    logic strobe_prev;
    logic enable_prev;
    logic strobe_rise;
    logic enable_rise;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strobe_prev <= 1'b0;
            enable_prev <= 1'b0;
        end
        else
        begin
            strobe_prev <= strobe_sync;
            enable_prev <= enable_sync;
        end
    end

    assign strobe_rise = strobe_sync & ~strobe_prev;
    assign enable_rise = enable_sync & ~enable_prev;

    // load sequencer
    // one load per strobe rise, however long it stays high
    // capture waits for two flops plus one edge stage
    // the shift word is quasi-static while the strobe is high: the controller
    // stops the serial clock before raising it, so it is read across domains
    // only after the synchronised strobe has risen.

    twr_pkg::twr_load_state_t state;
    twr_pkg::twr_load_state_t next_state;

    logic [WORD_W-1:0] captured_word;
    logic [CNT_W-1:0]  captured_count;
    logic [CNT_W-1:0]  last_count;
    logic              commit;

    always_comb
    begin
        next_state = state;
        case (state)
            twr_pkg::TWR_IDLE:
                if (strobe_rise)
                    next_state = twr_pkg::TWR_CAPTURE;
            twr_pkg::TWR_CAPTURE:
                next_state = twr_pkg::TWR_COMMIT;
            twr_pkg::TWR_COMMIT:
                next_state = twr_pkg::TWR_WAIT_LO;
            twr_pkg::TWR_WAIT_LO:
                if (!strobe_sync)
                    next_state = twr_pkg::TWR_IDLE;       // one load per strobe rise
            default:
                next_state = twr_pkg::TWR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state <= twr_pkg::TWR_IDLE;
        else
            state <= next_state;
    end

    // snapshot of the shift word and bit count, one cycle after the rise
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            captured_word  <= '0;
            captured_count <= twr_pkg::CNT_RESET;
        end
        else if (state == twr_pkg::TWR_CAPTURE)
        begin
            captured_word  <= shift_word;
            captured_count <= bit_count;
        end
    end

    assign commit = (state == twr_pkg::TWR_COMMIT);

    // word fields
    // select sits in the last bits shifted
    // bit count wraps at 256, enough to flag short words

    logic [SEL_W-1:0]  word_sel;
    logic [DATA_W-1:0] word_data;
    logic [CNT_W-1:0]  word_bits;

    assign word_sel  = captured_word[twr_pkg::SEL_LSB +: SEL_W];
    assign word_data = captured_word[twr_pkg::DATA_LSB +: DATA_W];
    assign word_bits = captured_count - last_count;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            last_count <= twr_pkg::CNT_RESET;
        else if (commit)
            last_count <= captured_count;
    end

    // latch register bank
    // one register per select code
    // registers change only on a commit

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1)
        begin : g_reg
            logic load_this;

            // only a commit from a strobe rise writes a register
            assign load_this = commit && (word_sel == SEL_W'(gi));

            twr_latch_reg
            #(
                .W     (DATA_W),
                .RESET (twr_pkg::REG_RESET)
            )
            u_reg
            (
                .sys_clk (sys_clk),
                .resetn  (resetn),
                .load    (load_this),
                .d       (word_data),
                .q       (reg_bank[gi*DATA_W +: DATA_W])
            );
        end
    endgenerate

    // load reporting
    // levels stand until the next load
    // the pulse lasts one system clock

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            load_pulse <= 1'b0;
            load_sel   <= '0;
            load_bits  <= '0;
            short_word <= 1'b0;
        end
        else
        begin
            load_pulse <= commit;
            if (commit)
            begin
                load_sel   <= word_sel;
                load_bits  <= 8'(word_bits);
                // longer words are fine, the leading bits fall off the top
                short_word <= (word_bits < CNT_W'(WORD_W));
            end
        end
    end

    // power control
    // enable gates the programmed sections
    // relock flag: set wins over clear

    logic [PWR_W-1:0] pwr_bits;
    logic             primary_write;

    assign pwr_bits      = reg_bank[32'(twr_pkg::PWR_SEL) * DATA_W + twr_pkg::PWR_LSB +: PWR_W];
    assign primary_write = commit && (word_sel == twr_pkg::PRIMARY_SEL);

    // enable gates the programmed sections; bits written while disabled take effect on enable
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwr_enable <= '0;
            powered    <= 1'b0;
        end
        else
        begin
            pwr_enable <= enable_sync ? pwr_bits : '0;
            powered    <= enable_sync;
        end
    end

    // the loop stays unlocked after power-up until the primary register is rewritten;
    // an enable rise in the same cycle as that write keeps the flag set
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            relock_pending <= 1'b0;
        else if (enable_rise)
            relock_pending <= 1'b1;
        else if (primary_write && enable_sync)
            relock_pending <= 1'b0;
    end

    // settle time checked against the capture delay: two sync flops plus the edge stage
    localparam int CAPTURE_DELAY = twr_pkg::SYNC_STAGES + 1;
    localparam bit SETTLE_OK     = (CAPTURE_DELAY >= twr_pkg::SETTLE_CYCLES);

    logic unused_ok;
    assign unused_ok = SETTLE_OK;

endmodule : twr_serial_port

`default_nettype wire

// file: rtl/twr_sync.sv
// two-flop level synchroniser into the system clock domain
`timescale 1ns/10ps
`default_nettype none

module twr_sync
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta;

    // first flop feeds only the second one
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : twr_sync

`default_nettype wire

// file: verification/twr_host_model.sv
// controller model driving the serial programming pins
`timescale 1ns/10ps
`default_nettype none
module twr_host_model
(
    // serial link pins
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // clock stands low between frames; data flips after a frame so no stale level is trusted
    task automatic send(input logic [31:0] w, input int n, input bit slow);
        for (int i = n - 1; i >= 0; i--)
        begin
            ser_data = w[i];
            #7.5 ser_clk = 1'b1;
            #7.5 ser_clk = 1'b0;
            if (slow)
                #30;
        end
        ser_data = ~ser_data;
    endtask : send

    // strobe held past the settle window, then low long enough for the next rise
    task automatic strobe();
        #20 latch_strobe = 1'b1;
        #300 latch_strobe = 1'b0;
        #150;
    endtask : strobe
endmodule : twr_host_model
`default_nettype wire

// file: verification/twr_properties.sv
// concurrent checks on the three-wire register load port
`timescale 1ns/10ps
`default_nettype none
module twr_props
(
    // clocks and reset
    input wire logic         sys_clk,
    input wire logic         resetn,
    input wire logic         ser_clk,
    // pins
    input wire logic         ser_data,
    input wire logic         latch_strobe,
    input wire logic         chip_enable,
    // outputs
    input wire logic [319:0] reg_bank,
    input wire logic         load_pulse,
    input wire logic [3:0]   load_sel,
    input wire logic [7:0]   load_bits,
    input wire logic         short_word,
    input wire logic [3:0]   pwr_enable,
    input wire logic         powered,
    input wire logic         relock_pending
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    pulse_single_a: assert property (load_pulse |=> !load_pulse) else $error("load pulse too long");
    strobe_load_a: assert property ($rose(latch_strobe) |-> ##[2:7] load_pulse) else $error("strobe lost");
    idle_hold_a: assert property (!latch_strobe [*8] |-> $stable(reg_bank) && !load_pulse)
        else $error("bank moved without strobe");
    bank_pulse_a: assert property (!$stable(reg_bank) |-> ##[0:1] load_pulse) else $error("silent bank write");
    short_flag_a: assert property (load_pulse |=> short_word == (load_bits < 8'h18)) else $error("short flag");
    pwr_gate_a: assert property (!powered && !$past(powered) |-> pwr_enable == 4'h0) else $error("power leak");
    pwr_bits_a: assert property (powered && $past(powered) |-> pwr_enable == $past(reg_bank[23:20]))
        else $error("power bits");
    enable_up_a: assert property ($rose(chip_enable) |-> ##[2:4] powered) else $error("no power up");
    relock_set_a: assert property ($rose(powered) |-> relock_pending) else $error("relock not set");
    relock_clr_a: assert property (load_pulse && load_sel == twr_pkg::PRIMARY_SEL && $past(powered, 3)
        |-> !relock_pending) else $error("relock not cleared");

    cover property (load_pulse && short_word);
    cover property ($rose(relock_pending));
    cover property (load_pulse && load_sel == twr_pkg::PWR_SEL && powered);
endmodule : twr_props
`default_nettype wire

// file: verification/twr_serial_port_tb.sv
// self-checking bench for the three-wire register load port
`timescale 1ns/10ps
`default_nettype none
module twr_serial_port_tb;
    logic         sys_clk;
    logic         resetn;
    logic         chip_enable;
    wire logic    ser_clk;
    wire logic    ser_data;
    wire logic    latch_strobe;
    logic [319:0] reg_bank;
    logic         load_pulse;
    logic [3:0]   load_sel;
    logic [7:0]   load_bits;
    logic         short_word;
    logic [3:0]   pwr_enable;
    logic         powered;
    logic         relock_pending;
    logic [19:0]  exp_reg [16];
    logic [23:0]  sr;
    int           nb;
    int           mismatches;
    int           n_compared;
    int           n_latched;
    int           n_loads = 0;

    twr_host_model host_u (.ser_clk, .ser_data, .latch_strobe);
    twr_serial_port dut_u (.sys_clk, .resetn, .ser_clk, .ser_data, .latch_strobe, .chip_enable, .reg_bank,
        .load_pulse, .load_sel, .load_bits, .short_word, .pwr_enable, .powered, .relock_pending);

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // one-cycle load pulses counted against the strobes sent
    always @(posedge sys_clk)
        if (load_pulse === 1'b1)
            n_loads <= n_loads + 1;

    function automatic logic [319:0] exp_bank();
        logic [319:0] b;
        for (int i = 0; i < 16; i++)
            b[i*20 +: 20] = exp_reg[i];
        return b;
    endfunction : exp_bank

    task automatic conclude();
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_bank();
        n_compared++;
        if (exp_bank() !== reg_bank)
        begin
            mismatches++;
            $display("ERROR reg_bank expected %h seen %h", exp_bank(), reg_bank);
        end
    endtask : chk_bank

    // shifts n bits, tracks the shift register, optionally strobes and checks the load
    task automatic word(input logic [31:0] w, input int n, input bit slow, input bit latch);
        host_u.send(w, n, slow);
        for (int i = n - 1; i >= 0; i--)
            sr = {sr[22:0], w[i]};
        nb += n;
        if (latch)
        begin
            host_u.strobe();
            exp_reg[sr[3:0]] = sr[23:4];
            chk_val("load_sel", 32'(sr[3:0]), 32'(load_sel));
            chk_val("load_bits", 32'(nb[7:0]), 32'(load_bits));
            chk_val("short_word", 32'(nb < 24), 32'(short_word));
            nb = 0;
            n_latched++;
        end
        chk_bank();
    endtask : word

    initial
    begin
        #1_000_000;
        mismatches++;
        conclude();
    end

    initial
    begin
        void'($urandom(61880));
        resetn = 1'b0;
        chip_enable = 1'b0;
        sr = 24'h00_0000;
        nb = 0;
        mismatches = 0;
        n_compared = 0;
        n_latched = 0;
        exp_reg = '{default: 20'h0_0000};
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk_bank();
        for (int i = 0; i < 16; i++)
            word(($urandom() & 32'hFFFF_FFF0) | 32'(i), 24, i[0], 1'b1);
        word($urandom(), 28, 1'b0, 1'b1);
        word($urandom(), 20, 1'b1, 1'b1);
        word($urandom(), 24, 1'b0, 1'b0);
        repeat (10) @(posedge sys_clk);
        chk_bank();
        word(32'h0000_0000, 0, 1'b0, 1'b1);
        // power bit 0 forced high here and low in the rewrite, so the enables must move
        word(($urandom() & 32'hFFFF_FFE0) | 32'h0000_0011, 24, 1'b0, 1'b1);
        @(posedge sys_clk);
        chip_enable <= 1'b1;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_val("powered", 32'h1, 32'(powered));
        chk_val("pwr_enable", 32'(exp_reg[1][3:0]), 32'(pwr_enable));
        chk_val("relock_pending", 32'h1, 32'(relock_pending));
        word(($urandom() & 32'hFFFF_FFE0) | 32'h0000_0021, 24, 1'b1, 1'b1);
        chk_val("pwr_enable", 32'(exp_reg[1][3:0]), 32'(pwr_enable));
        word($urandom() & 32'hFFFF_FFF0, 24, 1'b0, 1'b1);
        chk_val("relock_pending", 32'h0, 32'(relock_pending));
        @(posedge sys_clk);
        chip_enable <= 1'b0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_val("powered", 32'h0, 32'(powered));
        chk_val("pwr_enable", 32'h0, 32'(pwr_enable));
        chk_val("load_pulse", 32'(n_latched), 32'(n_loads));
        conclude();
    end
endmodule : twr_serial_port_tb

bind twr_serial_port twr_props chk_u (.sys_clk, .resetn, .ser_clk, .ser_data, .latch_strobe, .chip_enable,
    .reg_bank, .load_pulse, .load_sel, .load_bits, .short_word, .pwr_enable, .powered, .relock_pending);
`default_nettype wire
